/* shared/stm_pkg.sv */
//------------------------------------------------------------------------------
// Purpose: constants and types for the sequential trigger matcher
// Assumes: the trigger channel is user logic on the user clock; configuration
//          comes from a host-facing agent on the core clock
// Notes:   stage numbering is zero based inside the logic
//------------------------------------------------------------------------------
// Contract
// - trigger channel width is a parameter from 1 to 40 bits, host matches it
// - number of sequential trigger stages is configurable from one to three
// - post-trigger sampling starts only after the last enabled stage matches
// - with one stage, stages two and three are ignored; stage one fires
// - with two stages, stage two on any later clock after stage one fires
// - with three stages, stages one, two, three match on successively later clocks
// - pattern bit zero maps to channel 0, top bit to the top channel
// - each stage holds value, edge and don't-care masks per bit
// - don't-care bits are excluded from the stage match
// - rising edge bit matches only on the low to high cycle
// - falling edge bit matches only on the high to low cycle
// - level bits match every cycle the sample equals the level
// - an all don't-care stage matches on its first evaluated cycle
// - AND mode needs every cared bit to meet its condition
// - OR mode needs at least one cared bit to meet its condition
// - AND or OR choice is held separately for each stage
package stm_pkg;

    //--------------------------------------------------------------------------
    // sizes and reset values
    //--------------------------------------------------------------------------
    localparam int STM_CH_MIN = 1;
    localparam int STM_CH_MAX = 40;
    localparam int STM_STAGES = 3;
    localparam logic [1:0] STM_NSTG_RST = 2'h1;
    localparam logic [1:0] STM_STAGE_FIRST = 2'h0;
    localparam logic [2:0] STM_AND_RST = 3'h7;

    //--------------------------------------------------------------------------
    // user domain sequencer states, one-hot
    //--------------------------------------------------------------------------
    typedef enum logic [2:0]
    {
        STM_IDLE = 3'h1,
        STM_RUN = 3'h2,
        STM_DONE = 3'h4
    } stm_ustate_t;

    // index of the last enabled stage; a count of zero is taken as one
    function automatic logic [1:0] stm_last_stage(input logic [1:0] n);
        logic [1:0] r;
        r = 2'h0;
        if (n == 2'h0)
        begin
            r = 2'h0;
        end
        else
        begin
            r = n - 2'h1;
        end
        return r;
    endfunction

endpackage

/* rtl/stm_stage_match.sv */
//------------------------------------------------------------------------------
// Purpose: match one trigger stage against the current and previous sample
// Assumes: sample and previous sample come from the same user clock
// Notes:   purely combinational; holds no state
//------------------------------------------------------------------------------
module stm_stage_match
    import stm_pkg::*;
#(
    parameter int TW = 40
)
(
    input wire logic [TW-1:0] i_cur,
    input wire logic [TW-1:0] i_prev,
    input wire logic [TW-1:0] i_val,
    input wire logic [TW-1:0] i_edge,
    input wire logic [TW-1:0] i_dc,
    input wire logic i_and,
    output logic o_match
);

    logic [TW-1:0] hit;
    logic [TW-1:0] care;

    //--------------------------------------------------------------------------
    // per-bit condition and combine
    //--------------------------------------------------------------------------
    // per-bit hit: edge bits use value as rise or fall select, else level
    always_comb
    begin
        care = ~i_dc;
        for (int b = 0; b < TW; b++)
        begin
            if (i_edge[b] && i_val[b])
            begin
                hit[b] = ~i_prev[b] & i_cur[b];
            end
            else if (i_edge[b])
            begin
                hit[b] = i_prev[b] & ~i_cur[b];
            end
            else
            begin
                hit[b] = ~(i_cur[b] ^ i_val[b]);
            end
        end
        if (care == '0)
        begin
            o_match = 1'b1;
        end
        else if (i_and)
        begin
            // every cared bit, don't-care bits forced true
            o_match = &(hit | i_dc);
        end
        else
        begin
            // any cared bit, don't-care bits forced false
            o_match = |(hit & care);
        end
    end

endmodule

/* rtl/stm_trigger_matcher.sv */
//------------------------------------------------------------------------------
// Purpose: sequential trigger matcher of an on-chip logic analyser
// Assumes: I_USER_CLK runs free; I_TRIG_CH is logic on I_USER_CLK
// Notes:   configuration is latched on arm in the core domain and picked up
//          by the user domain through a toggle handshake; it must not change
//          while O_BUSY is high, which the core side itself guarantees
//------------------------------------------------------------------------------
module stm_trigger_matcher
    import stm_pkg::*;
#(
    parameter int TW = 40
)
(
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_ARM,
    input wire logic [1:0] I_NUM_STAGES,
    input wire logic [2:0] I_AND_MODE,
    input wire logic [2:0][TW-1:0] I_VAL_MASK,
    input wire logic [2:0][TW-1:0] I_EDGE_MASK,
    input wire logic [2:0][TW-1:0] I_DC_MASK,
    output logic O_BUSY,
    output logic O_ARMED,
    output logic O_TRIGGERED,
    input wire logic I_USER_CLK,
    input wire logic [TW-1:0] I_TRIG_CH,
    output logic O_POST_TRIG,
    output logic O_TRIG_HIT,
    output logic [1:0] O_STAGE
);

    //--------------------------------------------------------------------------
    // state types
    //--------------------------------------------------------------------------
    typedef struct packed {
        logic arm_tgl;
        logic ack_s1;
        logic ack_s2;
        logic ack_s3;
        logic hit_s1;
        logic hit_s2;
        logic hit_s3;
        logic busy;
        logic armed;
        logic triggered;
        logic [1:0] nstg;
        logic [2:0] and_m;
        logic [2:0][TW-1:0] val;
        logic [2:0][TW-1:0] edg;
        logic [2:0][TW-1:0] dc;
    } stm_core_t;

    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic arm_s1;
        logic arm_s2;
        logic arm_s3;
        logic ack_tgl;
        logic hit_tgl;
        stm_ustate_t state;
        logic [1:0] stage;
        logic [1:0] nstg;
        logic [2:0] and_m;
        logic [2:0][TW-1:0] val;
        logic [2:0][TW-1:0] edg;
        logic [2:0][TW-1:0] dc;
        logic [TW-1:0] prev;
        logic post;
        logic hit;
    } stm_user_t;

    stm_core_t c_q;
    stm_core_t c_d;
    stm_user_t u_q;
    stm_user_t u_d;
    logic [2:0] mt;
    logic arm_new;
    logic [1:0] last_u;
    logic fire_now;

    //--------------------------------------------------------------------------
    // core domain: arming, config latch, status
    //--------------------------------------------------------------------------
    // accept arm when idle, latch config, wait for user side acknowledge
    always_comb
    begin
        c_d = c_q;
        c_d.ack_s1 = u_q.ack_tgl;
        c_d.ack_s2 = c_q.ack_s1;
        c_d.ack_s3 = c_q.ack_s2;
        c_d.hit_s1 = u_q.hit_tgl;
        c_d.hit_s2 = c_q.hit_s1;
        c_d.hit_s3 = c_q.hit_s2;
        if (c_q.ack_s2 != c_q.ack_s3)
        begin
            c_d.busy = 1'b0; // user side has taken the config
        end
        if (I_ARM && !c_q.busy)
        begin
            c_d.arm_tgl = ~c_q.arm_tgl;
            c_d.busy = 1'b1;
            c_d.armed = 1'b1;
            c_d.triggered = 1'b0;
            // stage count latched with the patterns
            c_d.nstg = I_NUM_STAGES;
            c_d.and_m = I_AND_MODE;
            c_d.val = I_VAL_MASK;
            c_d.edg = I_EDGE_MASK;
            c_d.dc = I_DC_MASK;
        end
        // trigger report wins over a clear in the same cycle
        if (c_q.hit_s2 != c_q.hit_s3)
        begin
            c_d.armed = 1'b0;
            c_d.triggered = 1'b1;
        end
        if (I_RST)
        begin
            c_d = '0;
            c_d.nstg = STM_NSTG_RST;
            c_d.and_m = STM_AND_RST;
            c_d.dc = '1;
        end
    end

    always_ff @(posedge I_CORE_CLK)
    begin
        c_q <= c_d;
    end

    assign O_BUSY = c_q.busy;
    assign O_ARMED = c_q.armed;
    assign O_TRIGGERED = c_q.triggered;

    //--------------------------------------------------------------------------
    // user domain: stage matchers
    //--------------------------------------------------------------------------
    // one matcher per stage, all fed by the same current and previous sample
    for (genvar g = 0; g < STM_STAGES; g++)
    begin : g_stage
        stm_stage_match #(
            .TW(TW)
        ) u_match (
            .i_cur(I_TRIG_CH),
            .i_prev(u_q.prev),
            .i_val(u_q.val[g]),
            .i_edge(u_q.edg[g]),
            .i_dc(u_q.dc[g]),
            .i_and(u_q.and_m[g]),
            .o_match(mt[g])
        );
    end

    //--------------------------------------------------------------------------
    // user domain: sequencer
    //--------------------------------------------------------------------------
    // arm edge, last enabled stage
    assign arm_new = u_q.arm_s2 != u_q.arm_s3;
    assign last_u = stm_last_stage(u_q.nstg);
    assign fire_now = (u_q.state == STM_RUN) && (u_q.stage == last_u) && mt[u_q.stage];

    // walk the stages one per match, each on a later clock than the previous
    always_comb
    begin
        u_d = u_q;
        u_d.rst_s1 = I_RST;
        u_d.rst_s2 = u_q.rst_s1;
        u_d.arm_s1 = c_q.arm_tgl;
        u_d.arm_s2 = u_q.arm_s1;
        u_d.arm_s3 = u_q.arm_s2;
        u_d.prev = I_TRIG_CH;
        u_d.hit = 1'b0;
        if (u_q.rst_s2)
        begin
            u_d.arm_s3 = 1'b0;
            u_d.ack_tgl = 1'b0;
            u_d.hit_tgl = 1'b0;
            u_d.state = STM_IDLE;
            u_d.stage = STM_STAGE_FIRST;
            u_d.nstg = STM_NSTG_RST;
            u_d.and_m = STM_AND_RST;
            u_d.val = '0;
            u_d.edg = '0;
            u_d.dc = '1;
            u_d.prev = '0;
            u_d.post = 1'b0;
        end
        else if (arm_new)
        begin
            u_d.stage = STM_STAGE_FIRST;
            u_d.state = STM_RUN;
            u_d.post = 1'b0;
            u_d.ack_tgl = ~u_q.ack_tgl;
            // core side holds these steady while busy
            u_d.nstg = c_q.nstg;
            u_d.and_m = c_q.and_m;
            u_d.val = c_q.val;
            u_d.edg = c_q.edg;
            u_d.dc = c_q.dc;
        end
        else
        begin
            case (u_q.state)
                STM_RUN:
                begin
                    if (mt[u_q.stage])
                    begin
                        // fire only on the last enabled stage
                        if (u_q.stage == last_u)
                        begin
                            u_d.state = STM_DONE;
                            u_d.post = 1'b1;
                            u_d.hit = 1'b1;
                            u_d.hit_tgl = ~u_q.hit_tgl;
                        end
                        else
                        begin
                            // advance, next stage from the next clock
                            u_d.stage = u_q.stage + 2'h1;
                        end
                    end
                end
                default:
                begin
                    u_d.state = u_q.state;
                end
            endcase
        end
    end

    always_ff @(posedge I_USER_CLK)
    begin
        u_q <= u_d;
    end

    assign O_POST_TRIG = u_q.post;
    assign O_TRIG_HIT = u_q.hit;
    assign O_STAGE = u_q.stage;

    //--------------------------------------------------------------------------
    // checks
    //--------------------------------------------------------------------------
    // width in range
    a_width_range: assert property (@(posedge I_CORE_CLK)
        (TW >= STM_CH_MIN) && (TW <= STM_CH_MAX))
        else $error("trigger width out of range");

    // previous sample is last cycle's channel
    a_prev_sample: assert property (@(posedge I_USER_CLK)
        disable iff (u_q.rst_s2)
        1'b1 |=> u_q.prev == $past(I_TRIG_CH))
        else $error("previous sample not kept");

    // post-trigger only after the last stage matched
    a_post_last: assert property (@(posedge I_USER_CLK)
        disable iff (u_q.rst_s2)
        $rose(u_q.post) |-> $past(fire_now))
        else $error("post trigger without last stage match");

    // single stage fires on its own match
    a_one_stage: assert property (@(posedge I_USER_CLK)
        disable iff (u_q.rst_s2)
        (u_q.state == STM_RUN && u_q.nstg <= 2'h1 && mt[0] && !arm_new)
        |=> u_q.post && u_q.hit)
        else $error("single stage did not fire");

    // two stages: first match advances without firing
    a_two_stage: assert property (@(posedge I_USER_CLK)
        disable iff (u_q.rst_s2)
        (u_q.state == STM_RUN && u_q.nstg == 2'h2 && u_q.stage == 2'h0 && mt[0]
        && !arm_new) |=> !u_q.post ##0 u_q.stage == 2'h1)
        else $error("two stage sequence wrong");

    // three stages: second match advances to the third
    a_three_stage: assert property (@(posedge I_USER_CLK)
        disable iff (u_q.rst_s2)
        (u_q.state == STM_RUN && u_q.nstg == 2'h3 && u_q.stage == 2'h1 && mt[1]
        && !arm_new) |=> !u_q.post ##0 u_q.stage == 2'h2)
        else $error("three stage sequence wrong");

    a_arm_restart: assert property (@(posedge I_USER_CLK)
        disable iff (u_q.rst_s2)
        arm_new |=> u_q.stage == 2'h0 && u_q.state == STM_RUN && !u_q.post)
        else $error("arming did not restart sequence");

    a_all_dc: assert property (@(posedge I_USER_CLK)
        disable iff (u_q.rst_s2)
        (u_q.dc[0] == '1) |-> mt[0])
        else $error("all don't-care stage missed");

    // rising bit in AND mode needs a real rise
    a_rise_only: assert property (@(posedge I_USER_CLK)
        disable iff (u_q.rst_s2)
        (u_q.and_m[0] && !u_q.dc[0][0] && u_q.edg[0][0] && u_q.val[0][0]
        && !(!u_q.prev[0] && I_TRIG_CH[0])) |-> !mt[0])
        else $error("rising bit matched without rise");

    // OR mode with one cared level bit met matches
    a_or_any: assert property (@(posedge I_USER_CLK)
        disable iff (u_q.rst_s2)
        (!u_q.and_m[1] && !u_q.dc[1][0] && !u_q.edg[1][0]
        && I_TRIG_CH[0] == u_q.val[1][0]) |-> mt[1])
        else $error("or mode missed a met bit");

    // AND mode with a failed level bit does not match
    a_and_all: assert property (@(posedge I_USER_CLK)
        disable iff (u_q.rst_s2)
        (u_q.and_m[2] && !u_q.dc[2][0] && !u_q.edg[2][0]
        && I_TRIG_CH[0] != u_q.val[2][0]) |-> !mt[2])
        else $error("and mode matched with a failed bit");

    // busy clears within a bounded handshake time
    a_busy_bound: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
        $rose(c_q.busy) |-> ##[1:12] !c_q.busy)
        else $error("arm handshake stuck");

    c_fire_one: cover property (@(posedge I_USER_CLK) disable iff (u_q.rst_s2)
        $rose(u_q.post) && u_q.nstg == 2'h1);
    c_fire_two: cover property (@(posedge I_USER_CLK) disable iff (u_q.rst_s2)
        $rose(u_q.post) && u_q.nstg == 2'h2);
    c_fire_three: cover property (@(posedge I_USER_CLK) disable iff (u_q.rst_s2)
        $rose(u_q.post) && u_q.nstg == 2'h3);
    c_core_trig: cover property (@(posedge I_CORE_CLK) disable iff (I_RST)
        $rose(c_q.triggered));

endmodule

/* sim/stm_host_model.sv */
//------------------------------------------------------------------------------
// Purpose: host debugger model that loads stage patterns and arms the matcher
// Assumes: arm and configuration change just after a core clock edge
// Notes:   configuration stays put while the matcher reports busy
//------------------------------------------------------------------------------
module stm_host_model
    import stm_pkg::*;
#(
    parameter int TW = 6,
    parameter int REC_MAX = 128
)
(
    input wire logic i_clk,
    input wire logic i_busy,
    output logic o_arm,
    output logic [1:0] o_nstg,
    output logic [2:0] o_and,
    output logic [2:0][TW-1:0] o_val,
    output logic [2:0][TW-1:0] o_edge,
    output logic [2:0][TW-1:0] o_dc
);
    timeunit 1ns;
    timeprecision 100ps;

    int records;

    // idle host: count one, all stages don't care
    initial
    begin
        o_arm = 1'b0;
        o_nstg = 2'h1;
        o_and = 3'h7;
        o_val = '0;
        o_edge = '0;
        o_dc = '1;
        records = 0;
    end

    // load per-stage patterns, arm once per record
    task automatic arm_cfg(input logic [1:0] n, input logic [2:0] am,
        input logic [2:0][TW-1:0] v, input logic [2:0][TW-1:0] e,
        input logic [2:0][TW-1:0] d, output logic ok);
        int k;
        ok = 1'b0;
        for (k = 0; k < 50 && !ok; k++)
        begin
            @(posedge i_clk);
            #2;
            ok = (i_busy === 1'b0) && (records < REC_MAX);
        end
        if (ok)
        begin
            o_nstg = n;
            o_and = am;
            o_val = v;
            o_edge = e;
            o_dc = d;
            o_arm = 1'b1;
            @(posedge i_clk);
            #2;
            o_arm = 1'b0;
            records++;
        end
    endtask

    // immediate capture uses three all don't care stages
    task automatic arm_now(output logic ok);
        arm_cfg(2'h3, 3'h7, '0, '0, '1, ok);
    endtask
endmodule

/* sim/sequential_trigger_matcher_tb.sv */
//------------------------------------------------------------------------------
// Purpose: self-checking bench for the sequential trigger matcher
// Assumes: user clock 32 ns free running, core clock 100 ns
// Notes:   a bench model steps the stage sequence on each user clock
//------------------------------------------------------------------------------
module sequential_trigger_matcher_tb
    import stm_pkg::*;
#(
    parameter int TW = 6
);
    timeunit 1ns;
    timeprecision 100ps;

    logic core_clk = 1'b0;
    logic user_clk = 1'b0;
    logic rst = 1'b1;
    logic [TW-1:0] ch = '0;
    logic arm;
    logic [1:0] nstg;
    logic [2:0] andm;
    logic [2:0][TW-1:0] hv, he, hd;
    logic [2:0][TW-1:0] cv, ce, cd;
    logic busy, armed, trig, post, hit;
    logic [1:0] stage;
    int mismatches = 0;
    int n_compared = 0;

    always #50 core_clk = ~core_clk;
    always #16 user_clk = ~user_clk;

    stm_host_model #(.TW(TW)) host (.i_clk(core_clk), .i_busy(busy), .o_arm(arm),
        .o_nstg(nstg), .o_and(andm), .o_val(hv), .o_edge(he), .o_dc(hd));

    stm_trigger_matcher #(.TW(TW)) DUT (.I_CORE_CLK(core_clk), .I_RST(rst), .I_ARM(arm),
        .I_NUM_STAGES(nstg), .I_AND_MODE(andm), .I_VAL_MASK(hv), .I_EDGE_MASK(he),
        .I_DC_MASK(hd), .O_BUSY(busy), .O_ARMED(armed), .O_TRIGGERED(trig),
        .I_USER_CLK(user_clk), .I_TRIG_CH(ch), .O_POST_TRIG(post), .O_TRIG_HIT(hit),
        .O_STAGE(stage));

    //--------------------------------------------------------------------------
    // expectation and reporting helpers
    //--------------------------------------------------------------------------
    // expected stage match
    function automatic logic f_match(input logic [TW-1:0] c, input logic [TW-1:0] p,
        input logic [TW-1:0] v, input logic [TW-1:0] e, input logic [TW-1:0] d,
        input logic am);
        logic [TW-1:0] ok;
        ok = (e & v & c & ~p) | (e & ~v & ~c & p) | (~e & ~(c ^ v));
        if (&d)
            return 1'b1;
        return am ? &(ok | d) : |(ok & ~d);
    endfunction

    task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        n_compared++;
        if (ex !== got)
        begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, ex, got);
        end
    endtask

    task automatic final_report();
        if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // bounded wait for the arm handshake to finish
    task automatic wait_idle();
        int k;
        for (k = 0; k < 30 && busy !== 1'b0; k++)
        begin
            @(posedge core_clk);
            #2;
        end
        chk("busy_drop", 8'h0, {7'h0, busy});
        if (busy !== 1'b0)
            final_report();
    endtask

    // bounded wait for the trigger to reach the core side
    task automatic wait_trig();
        int k;
        for (k = 0; k < 12 && trig !== 1'b1; k++)
        begin
            @(posedge core_clk);
            #2;
        end
        chk("triggered", 8'h1, {7'h0, trig});
        chk("armed_end", 8'h0, {7'h0, armed});
        if (trig !== 1'b1)
            final_report();
    endtask

    task automatic do_arm(input logic [1:0] n, input logic [2:0] am);
        logic ok;
        host.arm_cfg(n, am, cv, ce, cd, ok);
        chk("arm_taken", 8'h1, {7'h0, ok});
        if (!ok)
            final_report();
        @(posedge core_clk);
        #2;
        chk("armed", 8'h1, {7'h0, armed});
        chk("trig_clear", 8'h0, {7'h0, trig});
        wait_idle();
    endtask

    //--------------------------------------------------------------------------
    // random patterns checked cycle by cycle against the bench model
    //--------------------------------------------------------------------------
    task automatic rand_test(input int cyc);
        logic [1:0] n, st, last;
        logic [2:0] am;
        logic [TW-1:0] held, cur, prev;
        logic pst, h, ok;
        int s, b, r, k;
        n = 2'($urandom % 4);
        am = 3'($urandom);
        for (s = 0; s < 3; s++)
            for (b = 0; b < TW; b++)
            begin
                r = $urandom % 8;
                cd[s][b] = (r < 4);
                ce[s][b] = (r == 4 || r == 5);
                cv[s][b] = (r == 4 || r == 7);
            end
        // quiet channel value that cannot fire the first stage while arming
        held = TW'($urandom);
        for (k = 0; k < 20 && f_match(held, held, cv[0], ce[0], cd[0], am[0]); k++)
            held = TW'($urandom);
        if (f_match(held, held, cv[0], ce[0], cd[0], am[0]))
        begin
            cd[0][0] = 1'b0;
            ce[0][0] = 1'b1;
            am[0] = 1'b1;
        end
        @(posedge user_clk);
        #2;
        ch = held;
        do_arm(n, am);
        last = (n == 2'h0) ? 2'h0 : n - 2'h1;
        st = 2'h0;
        pst = 1'b0;
        h = 1'b0;
        prev = held;
        repeat (cyc)
        begin
            @(posedge user_clk);
            #2;
            chk("post_trig", {7'h0, pst}, {7'h0, post});
            chk("trig_hit", {7'h0, h}, {7'h0, hit});
            if (!pst)
                chk("stage", {6'h0, st}, {6'h0, stage});
            cur = TW'($urandom);
            ch = cur;
            h = 1'b0;
            // one stage per cycle, edges against previous sample
            if (!pst && f_match(cur, prev, cv[st], ce[st], cd[st], am[st]))
            begin
                if (st == last)
                begin
                    pst = 1'b1;
                    h = 1'b1;
                end
                else
                    st = st + 2'h1;
            end
            prev = cur;
        end
        if (pst)
            wait_trig();
        else
        begin
            chk("still_armed", 8'h1, {7'h0, armed & ~trig});
            // end an unfinished sequence so no late trigger races the next arming
            host.arm_now(ok);
            chk("arm_flush", 8'h1, {7'h0, ok});
            if (!ok)
                final_report();
            wait_idle();
            wait_trig();
        end
        // let every toggle still crossing into the core domain land
        repeat (8) @(posedge core_clk);
        #2;
    endtask

    //--------------------------------------------------------------------------
    // main sequence
    //--------------------------------------------------------------------------
    initial
    begin
        logic ok;
        void'($urandom(32'hd35c));
        repeat (16) @(posedge core_clk);
        #2;
        chk("rst_core", 8'h0, {5'h0, busy, armed, trig});
        chk("rst_user", 8'h0, {4'h0, post, hit, stage});
        rst = 1'b0;
        repeat (4) @(posedge core_clk);
        host.arm_now(ok);
        chk("arm_now", 8'h1, {7'h0, ok});
        if (!ok)
            final_report();
        wait_idle();
        chk("immediate", 8'h1, {7'h0, post});
        wait_trig();
        repeat (30) rand_test(40);
        final_report();
    end

    // watchdog against a hung run
    initial
    begin
        #3ms;
        chk("watchdog", 8'h0, 8'h1);
        final_report();
    end
endmodule
